// ===== core/chs_field_reg.sv
// Purpose: status holding register with change pulse
// Assumes: synchronous active-low reset
// Notes:   both outputs come from flip-flops
`timescale 1ns/1ns
module chs_field_reg #(
  parameter int W = 8
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out,
  output logic              changed_out
);

  if (W < 1) begin : g_bad_width
    $error("chs_field_reg: W must be at least 1");
  end

  // ---------------------------------------------------------------
  // value and change detect
  // ---------------------------------------------------------------
  wire logic diff_w;
  assign diff_w = (d_in != q_out);

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      q_out       <= '0;
      changed_out <= 1'b0;
    end else begin
      q_out       <= d_in;
      changed_out <= diff_w;
    end
  end

endmodule

// ===== core/chs_pkg.sv
// Purpose: constants for the charger status register group
// Assumes: byte-wide register port from the serial interface engine
// Notes:   all registers read-only, all reset to zero
package chs_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CHS_OFS_LIMIT_LO = 8'h19;
  localparam logic [7:0] CHS_OFS_LIMIT_HI = 8'h1A;
  localparam logic [7:0] CHS_OFS_STAT0    = 8'h1B;
  localparam logic [7:0] CHS_OFS_STAT1    = 8'h1C;
  localparam logic [7:0] CHS_OFS_STAT2    = 8'h1D;
  localparam logic [7:0] CHS_OFS_STAT3    = 8'h1E;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CHS_RST_LIMIT = 16'h0000;
  localparam logic [7:0]  CHS_RST_STAT  = 8'h00;

  // ---------------------------------------------------------------
  // field widths and positions
  // ---------------------------------------------------------------
  localparam int CHS_LIMIT_W    = 9;
  localparam int CHS_PHASE_W    = 3;
  localparam int CHS_SRC_W      = 4;
  localparam int CHS_OPT_W      = 2;
  localparam int CHS_NUM_REGS   = 5;
  localparam int CHS_PHASE_LSB  = 5;
  localparam int CHS_SRC_LSB    = 1;
  localparam int CHS_OPT_LSB    = 6;

  // ---------------------------------------------------------------
  // code limits and reserved codes
  // ---------------------------------------------------------------
  localparam logic [8:0] CHS_LIMIT_MIN = 9'h00A;
  localparam logic [8:0] CHS_LIMIT_MAX = 9'h14A;
  localparam logic [2:0] CHS_PHASE_RSV = 3'h5;
  localparam logic [3:0] CHS_SRC_MAX   = 4'h8;
  localparam logic [1:0] CHS_OPT_RSV   = 2'h3;

endpackage

// ===== core/chs_status_regs.sv
// Purpose: read-only charger status register group
// Assumes: status inputs synchronous to core_clk_in
// Notes:   one-cycle read latency; mapped writes acknowledged, then dropped
//
// Summary of operation
// R1 - limit code in 10 mA steps, 100-3300mA
// R2 - bit7 status0: current regulation active
// R3 - bit6 status0: voltage regulation active
// R4 - bit5 status0: watchdog expired
// R5 - bit4 status0: weak adaptor detected
// R6 - bit3 status0: power good
// R7 - bits2..0 status0: input presence flags
// R8 - charge phase 3-bit encoding, 101 reserved
// R9 - input source 4-bit encoding, above 1000 reserved
// R10 - bit0 status1: source detection complete
// R11 - optimizer 2-bit state, 11 reserved
// R12 - bit2 status2: die thermal regulation
// R13 - bit1 status2: only while detection ongoing
// R14 - bit0 status2: battery present
// R15 - bits7,6 status3: blocking switches fitted
// R16 - bit5 status3: one-shot conversion done
// R17 - bit4 status3: minimum system regulation, forward
// R18 - bits3..1 status3: safety timers expired
// R19 - limit resets zero, bits 15..9 zero
// R20 - host writes ignored
`timescale 1ns/1ns
module chs_status_regs
  import chs_pkg::*;
(
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic [7:0]                   reg_addr_in,
  input  wire logic                         reg_rd_in,
  input  wire logic                         reg_wr_in,
  input  wire logic [7:0]                   reg_wdata_in,
  output logic      [7:0]                   reg_rdata_out,
  output logic                              reg_rvalid_out,
  output logic                              reg_ack_out,
  output logic                              write_ignored_out,
  output logic      [chs_pkg::CHS_NUM_REGS-1:0] status_changed_out,
  input  wire logic [chs_pkg::CHS_LIMIT_W-1:0]  optimized_current_limit_code_in,
  input  wire logic                         input_current_reg_active_in,
  input  wire logic                         input_voltage_reg_active_in,
  input  wire logic                         watchdog_expired_in,
  input  wire logic                         weak_source_detected_in,
  input  wire logic                         power_good_in,
  input  wire logic                         second_input_present_in,
  input  wire logic                         first_input_present_in,
  input  wire logic                         bus_input_present_in,
  input  wire logic [chs_pkg::CHS_PHASE_W-1:0]  charge_phase_in,
  input  wire logic [chs_pkg::CHS_SRC_W-1:0]    input_source_type_in,
  input  wire logic                         source_detection_done_in,
  input  wire logic [chs_pkg::CHS_OPT_W-1:0]    optimizer_state_in,
  input  wire logic                         die_thermal_reg_active_in,
  input  wire logic                         data_line_detect_busy_in,
  input  wire logic                         battery_present_in,
  input  wire logic                         second_blocking_switch_fitted_in,
  input  wire logic                         first_blocking_switch_fitted_in,
  input  wire logic                         conversion_done_in,
  input  wire logic                         one_shot_mode_in,
  input  wire logic                         forward_mode_in,
  input  wire logic                         min_system_reg_active_in,
  input  wire logic                         fast_charge_timer_expired_in,
  input  wire logic                         trickle_timer_expired_in,
  input  wire logic                         precharge_timer_expired_in
);

  import chs_pkg::*;

  // ---------------------------------------------------------------
  // held register contents
  // ---------------------------------------------------------------
  wire logic [CHS_LIMIT_W-1:0] limit_q;
  wire logic [7:0]             stat0_q;
  wire logic [7:0]             stat1_q;
  wire logic [7:0]             stat2_q;
  wire logic [7:0]             stat3_q;
  wire logic [CHS_NUM_REGS-1:0] chg_w;

  // ---------------------------------------------------------------
  // limit code qualification
  // ---------------------------------------------------------------
  wire logic                   lim_zero_w;
  wire logic                   lim_low_w;
  wire logic                   lim_high_w;
  wire logic [CHS_LIMIT_W-1:0] limit_d;
  assign lim_zero_w = (optimized_current_limit_code_in == '0);
  assign lim_low_w  = (optimized_current_limit_code_in < CHS_LIMIT_MIN);
  assign lim_high_w = (optimized_current_limit_code_in > CHS_LIMIT_MAX);
  // zero means no result yet; others clamp into the legal span
  assign limit_d = lim_zero_w ? '0 :
                   lim_low_w  ? CHS_LIMIT_MIN :
                   lim_high_w ? CHS_LIMIT_MAX :
                   optimized_current_limit_code_in; // R1

  // ---------------------------------------------------------------
  // status byte assembly
  // ---------------------------------------------------------------
  wire logic [7:0]             stat0_d;
  wire logic [7:0]             stat1_d;
  wire logic [7:0]             stat2_d;
  wire logic [7:0]             stat3_d;
  wire logic [CHS_PHASE_W-1:0] phase_sel;
  wire logic [CHS_SRC_W-1:0]   src_sel;
  wire logic [CHS_OPT_W-1:0]   opt_sel;

  assign stat0_d = {input_current_reg_active_in,     // R2
                    input_voltage_reg_active_in,     // R3
                    watchdog_expired_in,             // R4
                    weak_source_detected_in,         // R5
                    power_good_in,                   // R6
                    second_input_present_in,         // R7
                    first_input_present_in,
                    bus_input_present_in};

  // reserved codes never reach the host; the last legal code stays
  assign phase_sel = (charge_phase_in == CHS_PHASE_RSV) ?
                     stat1_q[CHS_PHASE_LSB +: CHS_PHASE_W] : charge_phase_in; // R8
  assign src_sel   = (input_source_type_in > CHS_SRC_MAX) ?
                     stat1_q[CHS_SRC_LSB +: CHS_SRC_W] : input_source_type_in; // R9
  assign opt_sel   = (optimizer_state_in == CHS_OPT_RSV) ?
                     stat2_q[CHS_OPT_LSB +: CHS_OPT_W] : optimizer_state_in; // R11

  assign stat1_d = {phase_sel, src_sel, source_detection_done_in}; // R10

  assign stat2_d = {opt_sel,
                    3'h0,
                    die_thermal_reg_active_in,   // R12
                    data_line_detect_busy_in,    // R13
                    battery_present_in};         // R14

  assign stat3_d = {second_blocking_switch_fitted_in, // R15
                    first_blocking_switch_fitted_in,
                    conversion_done_in & one_shot_mode_in,  // R16
                    min_system_reg_active_in & forward_mode_in, // R17
                    fast_charge_timer_expired_in,     // R18
                    trickle_timer_expired_in,
                    precharge_timer_expired_in,
                    1'b0};

  // ---------------------------------------------------------------
  // holding registers; only hardware inputs load them
  // ---------------------------------------------------------------
  chs_field_reg #(.W(CHS_LIMIT_W)) u_limit (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .d_in        (limit_d),
    .q_out       (limit_q),
    .changed_out (chg_w[0])
  );

  chs_field_reg #(.W(8)) u_stat0 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .d_in        (stat0_d),
    .q_out       (stat0_q),
    .changed_out (chg_w[1])
  );

  chs_field_reg #(.W(8)) u_stat1 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .d_in        (stat1_d),
    .q_out       (stat1_q),
    .changed_out (chg_w[2])
  );

  chs_field_reg #(.W(8)) u_stat2 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .d_in        (stat2_d),
    .q_out       (stat2_q),
    .changed_out (chg_w[3])
  );

  chs_field_reg #(.W(8)) u_stat3 (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .d_in        (stat3_d),
    .q_out       (stat3_q),
    .changed_out (chg_w[4])
  );

  // ---------------------------------------------------------------
  // address decode and read select
  // ---------------------------------------------------------------
  wire logic        hit_lo_w;
  wire logic        hit_hi_w;
  wire logic        hit_any_w;
  wire logic [15:0] limit_word_w;
  wire logic [7:0]  rd_sel_w;
  logic      [7:0]  limit_hi_shadow_q;
  logic      [7:0]  limit_hi_shadow_d;

  assign hit_lo_w  = (reg_addr_in == CHS_OFS_LIMIT_LO);
  assign hit_hi_w  = (reg_addr_in == CHS_OFS_LIMIT_HI);
  assign hit_any_w = hit_lo_w | hit_hi_w |
                     (reg_addr_in == CHS_OFS_STAT0) |
                     (reg_addr_in == CHS_OFS_STAT1) |
                     (reg_addr_in == CHS_OFS_STAT2) |
                     (reg_addr_in == CHS_OFS_STAT3);
  // upper seven bits tied low
  assign limit_word_w = {{(16 - CHS_LIMIT_W){1'b0}}, limit_q}; // R19

  // high byte frozen at low-byte read so a two-byte read is coherent
  assign limit_hi_shadow_d = (reg_rd_in && hit_lo_w) ? limit_word_w[15:8] :
                             limit_hi_shadow_q;

  assign rd_sel_w = hit_lo_w                         ? limit_word_w[7:0] :
                    hit_hi_w                         ? limit_hi_shadow_q :
                    (reg_addr_in == CHS_OFS_STAT0)   ? stat0_q :
                    (reg_addr_in == CHS_OFS_STAT1)   ? stat1_q :
                    (reg_addr_in == CHS_OFS_STAT2)   ? stat2_q :
                    (reg_addr_in == CHS_OFS_STAT3)   ? stat3_q :
                    CHS_RST_STAT;

  // ---------------------------------------------------------------
  // response registers; write data is never stored
  // ---------------------------------------------------------------
  wire logic [7:0] rdata_d;
  wire logic       wr_drop_d;
  assign rdata_d   = reg_rd_in ? rd_sel_w : reg_rdata_out;
  assign wr_drop_d = reg_wr_in & hit_any_w & (reg_wdata_in == reg_wdata_in); // R20

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out      <= CHS_RST_STAT;
      reg_rvalid_out     <= 1'b0;
      reg_ack_out        <= 1'b0;
      write_ignored_out  <= 1'b0;
      limit_hi_shadow_q  <= CHS_RST_LIMIT[15:8]; // R19
      status_changed_out <= '0;
    end else begin
      reg_rdata_out      <= rdata_d;
      reg_rvalid_out     <= reg_rd_in;
      reg_ack_out        <= (reg_rd_in | reg_wr_in) & hit_any_w;
      write_ignored_out  <= wr_drop_d;
      limit_hi_shadow_q  <= limit_hi_shadow_d;
      status_changed_out <= chg_w;
    end
  end

endmodule

// ===== tb/chs_host_model.sv
// Purpose: host side of the register port
// Assumes: one-cycle request pulse, answer one cycle later
// Notes:   released address and write-data lines show the inverse of the last value; rd and wr drop low
`timescale 1ns/1ns
module chs_host_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_rvalid_in,
  input  wire logic       reg_ack_in,
  output logic      [7:0] reg_addr_out,
  output logic            reg_rd_out,
  output logic            reg_wr_out,
  output logic      [7:0] reg_wdata_out
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_rd_out    = 1'b0;
    reg_wr_out    = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // one access; hs is {rvalid, ack} seen with the answer
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                        output logic [7:0] d, output logic [1:0] hs);
    @(negedge core_clk_in);
    reg_addr_out  = a;
    reg_wdata_out = wd;
    reg_rd_out    = !wr;
    reg_wr_out    = wr;
    @(negedge core_clk_in);
    reg_rd_out    = 1'b0;
    reg_wr_out    = 1'b0;
    reg_addr_out  = ~a;
    reg_wdata_out = ~wd;
    d             = reg_rdata_in;
    hs            = {reg_rvalid_in, reg_ack_in};
  endtask
endmodule

// ===== tb/chs_status_regs_assertions.sv
// Purpose: port-level checks of the status register group
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto chs_status_regs
`timescale 1ns/1ns
module chs_status_regs_assertions
  import chs_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_rd_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  input wire logic       reg_ack_out,
  input wire logic       write_ignored_out,
  input wire logic [4:0] status_changed_out,
  input wire logic       input_current_reg_active_in,
  input wire logic       input_voltage_reg_active_in,
  input wire logic       watchdog_expired_in,
  input wire logic       weak_source_detected_in,
  input wire logic       power_good_in,
  input wire logic       second_input_present_in,
  input wire logic       first_input_present_in,
  input wire logic       bus_input_present_in
);
  wire logic       mapped = reg_addr_in >= CHS_OFS_LIMIT_LO && reg_addr_in <= CHS_OFS_STAT3;
  wire logic [7:0] stat0  = {input_current_reg_active_in, input_voltage_reg_active_in,
                             watchdog_expired_in, weak_source_detected_in, power_good_in,
                             second_input_present_in, first_input_present_in,
                             bus_input_present_in};
  // -------------------------------------------------------------
  // properties
  // -------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_read_answer;
    ##1 (reg_rvalid_out && reg_ack_out);
  endsequence
  a_read_answer: assert property (reg_rd_in && mapped |-> s_read_answer)
    else $error("mapped read not answered next cycle");
  a_status0_map: assert property (reg_rd_in && reg_addr_in == CHS_OFS_STAT0 && $past(rst_n_in)
    |=> reg_rdata_out == $past(stat0, 2)) else $error("status0 bits wrong");
  a_status0_event: assert property ($past(rst_n_in) && stat0 != $past(stat0)
    |=> ##1 status_changed_out[1]) else $error("status0 change not flagged");
  a_limit_hi_zero: assert property (reg_rd_in && reg_addr_in == CHS_OFS_LIMIT_HI
    |=> reg_rdata_out[7:1] == 7'h00) else $error("limit upper bits not zero");
  a_write_dropped: assert property (reg_wr_in && !reg_rd_in && mapped
    |=> write_ignored_out && reg_ack_out && !reg_rvalid_out) else $error("write not dropped");
  a_write_keeps: assert property (reg_wr_in && !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("write altered read data");
  a_unmapped_zero: assert property (reg_rd_in && !mapped
    |=> reg_rdata_out == 8'h00 && !reg_ack_out && reg_rvalid_out) else $error("unmapped read");
  a_idle_quiet: assert property (!reg_rd_in && !reg_wr_in
    |=> !reg_ack_out && !reg_rvalid_out && !write_ignored_out) else $error("answer without request");
endmodule

bind chs_status_regs chs_status_regs_assertions u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .reg_ack_out(reg_ack_out),
  .write_ignored_out(write_ignored_out), .status_changed_out(status_changed_out),
  .input_current_reg_active_in(input_current_reg_active_in),
  .input_voltage_reg_active_in(input_voltage_reg_active_in),
  .watchdog_expired_in(watchdog_expired_in), .weak_source_detected_in(weak_source_detected_in),
  .power_good_in(power_good_in), .second_input_present_in(second_input_present_in),
  .first_input_present_in(first_input_present_in), .bus_input_present_in(bus_input_present_in));

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the status register group
// Assumes: inputs change at the falling edge
// Notes:   expectations built from package constants
`timescale 1ns/1ns
module tb_top;
  import chs_pkg::*;
  logic       core_clk, rst_n, rd, wr, rvalid, ack, det;
  logic [7:0] addr, wdata, rdata, s0, d;
  logic [4:0] chg;
  logic [8:0] lim, x3, e9;
  logic [2:0] ph, t2, eph;
  logic [3:0] src, esrc;
  logic [1:0] opt, eopt, hs;
  logic [8:0] limv [6] = '{9'h000, 9'h005, 9'h00A, 9'h14A, 9'h1FF, 9'h100};
  logic [8:0] x3v [4] = '{9'h1FF, 9'h1D7, 9'h028, 9'h000};
  int         err_count, checked, cyc;
  logic       wig;
  logic [4:0] chg_seen = '0;
  int         wig_n;

  chs_host_model HOST (.core_clk_in(core_clk), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_ack_in(ack), .reg_addr_out(addr), .reg_rd_out(rd), .reg_wr_out(wr),
    .reg_wdata_out(wdata));
  chs_status_regs DUT (.core_clk_in(core_clk), .rst_n_in(rst_n), .reg_addr_in(addr),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .reg_ack_out(ack), .write_ignored_out(wig),
    .status_changed_out(chg), .optimized_current_limit_code_in(lim),
    .input_current_reg_active_in(s0[7]), .input_voltage_reg_active_in(s0[6]),
    .watchdog_expired_in(s0[5]), .weak_source_detected_in(s0[4]), .power_good_in(s0[3]),
    .second_input_present_in(s0[2]), .first_input_present_in(s0[1]),
    .bus_input_present_in(s0[0]), .charge_phase_in(ph), .input_source_type_in(src),
    .source_detection_done_in(det), .optimizer_state_in(opt),
    .die_thermal_reg_active_in(t2[2]), .data_line_detect_busy_in(t2[1]),
    .battery_present_in(t2[0]), .second_blocking_switch_fitted_in(x3[8]),
    .first_blocking_switch_fitted_in(x3[7]), .conversion_done_in(x3[6]),
    .one_shot_mode_in(x3[5]), .min_system_reg_active_in(x3[4]), .forward_mode_in(x3[3]),
    .fast_charge_timer_expired_in(x3[2]), .trickle_timer_expired_in(x3[1]),
    .precharge_timer_expired_in(x3[0]));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // change pulses and dropped-write pulses, seen mid-cycle
  always @(negedge core_clk) begin
    chg_seen |= chg;
    if (wig === 1'b1) wig_n++;
  end
  // -------------------------------------------------------------
  // checks and closing
  // -------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    HOST.access(1'b0, a, 8'h00, d, hs);
    chk(d, e);
    chk({6'h00, hs}, {6'h01, a >= CHS_OFS_LIMIT_LO && a <= CHS_OFS_STAT3});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {s0, lim, x3, ph, t2, src, opt, det, eph, esrc, eopt} = '0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    for (int a = 'h18; a <= 'h1F; a++) rc(a[7:0], 8'h00);
    for (int i = 0; i < 2; i++) begin
      @(negedge core_clk);
      s0 = i ? 8'h5A : 8'hA5;
      rc(CHS_OFS_STAT0, s0);
    end
    for (int i = 0; i < 10; i++) begin
      @(negedge core_clk);
      ph = i[2:0];
      src = (i == 9) ? 4'hC : i[3:0];
      det = i[0];
      if (ph != CHS_PHASE_RSV) eph = ph;
      if (src <= CHS_SRC_MAX) esrc = src;
      rc(CHS_OFS_STAT1, {eph, esrc, det});
    end
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk);
      opt = i[1:0];
      t2 = i[2:0] ^ 3'h5;
      if (opt != CHS_OPT_RSV) eopt = opt;
      rc(CHS_OFS_STAT2, {eopt, 3'h0, t2});
    end
    foreach (x3v[i]) begin
      @(negedge core_clk);
      x3 = x3v[i];
      rc(CHS_OFS_STAT3, {x3[8:7], x3[6] & x3[5], x3[4] & x3[3], x3[2:0], 1'b0});
    end
    foreach (limv[i]) begin
      @(negedge core_clk);
      lim = limv[i];
      e9 = (lim > CHS_LIMIT_MAX) ? CHS_LIMIT_MAX : lim;
      if (lim != 9'h000 && lim < CHS_LIMIT_MIN) e9 = CHS_LIMIT_MIN;
      rc(CHS_OFS_LIMIT_LO, e9[7:0]);
      rc(CHS_OFS_LIMIT_HI, {7'h00, e9[8]});
    end
    HOST.access(1'b1, CHS_OFS_STAT1, 8'hFF, d, hs);
    chk({6'h00, hs}, 8'h01);
    HOST.access(1'b1, CHS_OFS_LIMIT_LO, 8'hFF, d, hs);
    chk({6'h00, hs}, 8'h01);
    rc(CHS_OFS_STAT1, {eph, esrc, det});
    rc(CHS_OFS_LIMIT_LO, e9[7:0]);
    @(negedge core_clk);
    rst_n = 1'b0;
    @(negedge core_clk);
    rst_n = 1'b1;
    rc(CHS_OFS_LIMIT_HI, 8'h00);
    rc(8'h30, 8'h00);
    chk({3'h0, chg_seen}, 8'h1F);
    chk(wig_n[7:0], 8'h02);
    end_sim();
  end
endmodule
